// ### hdl/scsi_initiator_pkg.sv
// constants, types and helpers shared by the bus initiator files
package scsi_initiator_pkg;

	// ============================================================
	// timing
	localparam int CLOCK_PERIOD_NS = 8;
	localparam int COUNT_WIDTH     = 16;

	function automatic int min_cycles(input int ns);
		int c;
		c = (ns + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int RESET_HOLD_NS        = 25000;
	localparam int BUS_CLEAR_NS         = 800;
	localparam int ARBITRATION_DELAY_NS = 2400;
	localparam int BUS_SETTLE_NS        = 400;
	localparam int DATA_SETUP_NS        = 90;
	localparam int SELECT_TIMEOUT_NS    = 250000;

	localparam logic [COUNT_WIDTH-1:0] RESET_HOLD_CYCLES = COUNT_WIDTH'(min_cycles(RESET_HOLD_NS));
	localparam logic [COUNT_WIDTH-1:0] BUS_CLEAR_CYCLES  = COUNT_WIDTH'(min_cycles(BUS_CLEAR_NS));
	localparam logic [COUNT_WIDTH-1:0] ARBITRATION_CYCLES = COUNT_WIDTH'(min_cycles(ARBITRATION_DELAY_NS));
	localparam logic [COUNT_WIDTH-1:0] BUS_SETTLE_CYCLES = COUNT_WIDTH'(min_cycles(BUS_SETTLE_NS));
	localparam logic [COUNT_WIDTH-1:0] DATA_SETUP_CYCLES = COUNT_WIDTH'(min_cycles(DATA_SETUP_NS));
	localparam int SELECT_TIMEOUT_DEFAULT = min_cycles(SELECT_TIMEOUT_NS);

	// ============================================================
	// identity and bus lines
	localparam logic [2:0] HOST_ID = 3'h7;

	typedef struct packed {
		logic       rst;
		logic       atn;
		logic       ack;
		logic       req;
		logic       msg;
		logic       cd;
		logic       io;
		logic       sel;
		logic       bsy;
		logic [7:0] data;
		logic       parity;
	} bus_type;

	localparam logic [17:0] BUS_IDLE        = 18'h00000;
	localparam logic [17:0] ATN_MASK        = 18'h10000;
	localparam logic [17:0] RESET_PINS      = 18'h20000;
	localparam logic [17:0] RESET_ENABLES_N = 18'h1FFFF;

	typedef enum logic [2:0] {
		PHASE_DATA_OUT = 3'b000,
		PHASE_DATA_IN  = 3'b001,
		PHASE_COMMAND  = 3'b010,
		PHASE_STATUS   = 3'b011,
		PHASE_MSG_OUT  = 3'b110,
		PHASE_MSG_IN   = 3'b111
	} phase_type;

	typedef enum logic [3:0] {
		ST_RESET    = 4'h0,
		ST_FREE     = 4'h1,
		ST_ARB_WAIT = 4'h2,
		ST_ARBITRATE = 4'h3,
		ST_SELECT   = 4'h4,
		ST_SEL_WAIT = 4'h5,
		ST_INFO     = 4'h6,
		ST_DRIVE    = 4'h7,
		ST_ACK      = 4'h8
	} state_type;

	// ============================================================
	// helpers
	function automatic logic odd_parity(input logic [7:0] d);
		return ~(^d);
	endfunction

	function automatic logic [7:0] id_bit(input logic [2:0] id);
		return 8'h01 << id;
	endfunction

	function automatic logic higher_id_present(input logic [7:0] d, input logic [2:0] id);
		logic found;
		found = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (i > int'(id) && d[i])
				found = 1'b1;
		end
		return found;
	endfunction

	// open-drain control lines are enabled only while asserted
	function automatic bus_type line_enables_n(input bus_type v, input logic dataOn);
		bus_type e;
		e        = bus_type'(RESET_ENABLES_N | 18'h3FFFF);
		e.rst    = ~v.rst;
		e.atn    = ~v.atn;
		e.ack    = ~v.ack;
		e.sel    = ~v.sel;
		e.bsy    = ~v.bsy;
		e.data   = {8{~dataOn}};
		e.parity = ~dataOn;
		return e;
	endfunction

endpackage

// ### hdl/scsi_phase_decode.sv
// decodes the information transfer phase from the target's lines
module scsi_phase_decode
	import scsi_initiator_pkg::*;
(
	input  wire bus_type   lines,
	output phase_type      phase,
	output logic           phaseLegal
);

	assign phase      = phase_type'({lines.msg, lines.cd, lines.io});
	// message asserted with control/data negated is no phase
	assign phaseLegal = ~(lines.msg & ~lines.cd);

endmodule // scsi_phase_decode

// ### hdl/scsi_bus_initiator.sv
// bus initiator at a fixed id: reset, arbitration, selection and byte handshakes
module scsi_bus_initiator
	import scsi_initiator_pkg::*;
#(
	parameter int SELECT_TIMEOUT_CYCLES = SELECT_TIMEOUT_DEFAULT
)(
	input  wire logic       clock,
	input  wire logic       reset,
	input  wire logic       startRequest,
	input  wire logic [2:0] targetId,
	input  wire logic       attentionRequest,
	input  wire logic       busResetRequest,
	input  wire logic [7:0] outByte,
	input  wire logic       outValid,
	input  wire logic       outLast,
	output logic            outReady,
	output logic [7:0]      inByte,
	output logic            inValid,
	output phase_type       inPhase,
	output phase_type       busPhase,
	output logic            busy,
	output logic            done,
	output logic            selectFailed,
	input  wire bus_type    busIn,
	output bus_type         busOut,
	output bus_type         busOe_n
);

	// ============================================================
	// state
	state_type              state;
	bus_type                drive;
	logic                   dataOn;
	logic                   attention;
	logic [2:0]             target;
	logic [COUNT_WIDTH-1:0] count;
	phase_type              phase;
	logic                   phaseLegal;
	bus_type                next_busOut;

	scsi_phase_decode decoder (
		.lines      (busIn),
		.phase      (phase),
		.phaseLegal (phaseLegal)
	);

	wire logic requestSeen  = busIn.bsy & busIn.req & phaseLegal;
	wire logic takeOut      = state == ST_INFO && requestSeen && !busIn.io && outValid;
	// the host's own reset pin lags its state by one cycle; only a reset from another unit counts
	wire logic foreignReset = busIn.rst && !busOut.rst && state != ST_RESET;

	// ============================================================
	// sequencer
	always_ff @(posedge clock) begin
		outReady     <= 1'b0;
		inValid      <= 1'b0;
		done         <= 1'b0;
		selectFailed <= 1'b0;
		if (count != {COUNT_WIDTH{1'b1}})
			count <= count + 1'b1;
		if (reset || busResetRequest) begin
			state  <= ST_RESET;
			drive  <= bus_type'(RESET_PINS);
			dataOn <= 1'b0;
			count  <= '0;
			busy   <= 1'b1;
			target <= 3'h0;
			inByte <= 8'h00;
			inPhase <= PHASE_DATA_IN;
			busPhase <= PHASE_DATA_OUT;
		end else if (foreignReset) begin
			state  <= ST_FREE;
			drive  <= bus_type'(BUS_IDLE);
			dataOn <= 1'b0;
			count  <= '0;
			busy   <= 1'b0;
			done   <= busy;
		end else begin
			unique case (state)
				ST_RESET: begin
					if (count >= RESET_HOLD_CYCLES) begin
						drive <= bus_type'(BUS_IDLE);
						state <= ST_FREE;
						count <= '0;
						busy  <= 1'b0;
					end
				end
				ST_FREE: begin
					if (startRequest) begin
						target <= targetId;
						busy   <= 1'b1;
						state  <= ST_ARB_WAIT;
						count  <= '0;
					end
				end
				ST_ARB_WAIT: begin
					if (busIn.bsy || busIn.sel) begin
						count <= '0;
					end else if (count >= BUS_CLEAR_CYCLES) begin
						drive.bsy  <= 1'b1;
						drive.data <= id_bit(HOST_ID);
						drive.parity <= odd_parity(id_bit(HOST_ID));
						dataOn     <= 1'b1;
						state      <= ST_ARBITRATE;
						count      <= '0;
					end
				end
				ST_ARBITRATE: begin
					if (count >= ARBITRATION_CYCLES) begin
						count <= '0;
						if (higher_id_present(busIn.data, HOST_ID) || busIn.sel) begin
							drive  <= bus_type'(BUS_IDLE);
							dataOn <= 1'b0;
							state  <= ST_ARB_WAIT;
						end else begin
							drive.sel <= 1'b1;
							state     <= ST_SELECT;
						end
					end
				end
				ST_SELECT: begin
					if (count >= BUS_SETTLE_CYCLES) begin
						drive.data   <= id_bit(HOST_ID) | id_bit(target);
						drive.parity <= odd_parity(id_bit(HOST_ID) | id_bit(target));
						drive.bsy    <= 1'b0;
						state        <= ST_SEL_WAIT;
						count        <= '0;
					end
				end
				ST_SEL_WAIT: begin
					if (count >= BUS_SETTLE_CYCLES && busIn.bsy) begin
						drive  <= bus_type'(BUS_IDLE);
						dataOn <= 1'b0;
						state  <= ST_INFO;
						count  <= '0;
					end else if (count >= COUNT_WIDTH'(SELECT_TIMEOUT_CYCLES)) begin
						drive        <= bus_type'(BUS_IDLE);
						dataOn       <= 1'b0;
						selectFailed <= 1'b1;
						done         <= 1'b1;
						busy         <= 1'b0;
						state        <= ST_FREE;
						count        <= '0;
					end
				end
				ST_INFO: begin
					count <= '0;
					if (!busIn.bsy) begin
						done  <= 1'b1;
						busy  <= 1'b0;
						state <= ST_FREE;
					end else if (requestSeen && busIn.io) begin
						inByte    <= busIn.data;
						inPhase   <= phase;
						busPhase  <= phase;
						inValid   <= 1'b1;
						drive.ack <= 1'b1;
						state     <= ST_ACK;
					end else if (takeOut) begin
						drive.data   <= outByte;
						drive.parity <= odd_parity(outByte);
						dataOn       <= 1'b1;
						outReady     <= 1'b1;
						busPhase     <= phase;
						state        <= ST_DRIVE;
					end
				end
				ST_DRIVE: begin
					if (count >= DATA_SETUP_CYCLES) begin
						drive.ack <= 1'b1;
						state     <= ST_ACK;
						count     <= '0;
					end
				end
				ST_ACK: begin
					if (!busIn.bsy) begin
						drive  <= bus_type'(BUS_IDLE);
						dataOn <= 1'b0;
						done   <= 1'b1;
						busy   <= 1'b0;
						state  <= ST_FREE;
					end else if (!busIn.req) begin
						drive.ack <= 1'b0;
						dataOn    <= 1'b0;
						state     <= ST_INFO;
					end
				end
			endcase
		end
	end

	// ============================================================
	// attention: a new request wins over the clear by the last message byte
	always_ff @(posedge clock) begin
		if (reset || busResetRequest || foreignReset)
			attention <= 1'b0;
		else if (attentionRequest && busy)
			attention <= 1'b1;
		else if (state == ST_FREE || (takeOut && phase == PHASE_MSG_OUT && outLast))
			attention <= 1'b0;
	end

	// ============================================================
	// pins
	always_comb begin
		next_busOut = attention ? bus_type'(drive | ATN_MASK) : drive;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			busOut  <= bus_type'(RESET_PINS);
			busOe_n <= bus_type'(RESET_ENABLES_N);
		end else begin
			busOut  <= next_busOut;
			busOe_n <= line_enables_n(next_busOut, dataOn);
		end
	end

	// ============================================================
	// checks
	host_id_a: assert property (@(posedge clock) disable iff (reset)
		state == ST_ARBITRATE |-> drive.data == 8'h80 && drive.bsy)
		else $error("arbitration id is not the host id");

	parity_ok_a: assert property (@(posedge clock) disable iff (reset)
		!busOe_n.parity |-> busOut.parity == ~(^busOut.data))
		else $error("driven parity is wrong");

	select_after_arb_a: assert property (@(posedge clock) disable iff (reset)
		$rose(drive.sel) |-> state == ST_SELECT && $past(state) == ST_ARBITRATE)
		else $error("select raised outside arbitration win");

	arb_from_free_a: assert property (@(posedge clock) disable iff (reset)
		$rose(drive.bsy) |-> $past(state) == ST_ARB_WAIT && $past(busIn.bsy) == 1'b0)
		else $error("arbitration not entered from bus free");

	ack_answer_a: assert property (@(posedge clock) disable iff (reset)
		state == ST_INFO && requestSeen && busIn.io && !busIn.rst && !busResetRequest
		|=> drive.ack ##1 busOut.ack)
		else $error("request not acknowledged");

	ack_release_a: assert property (@(posedge clock) disable iff (reset)
		state == ST_ACK && busIn.bsy && !busIn.req && !busIn.rst && !busResetRequest
		|=> !drive.ack && !dataOn ##1 !busOut.ack)
		else $error("acknowledge held after request negated");

	startup_reset_a: assert property (@(posedge clock) disable iff (reset)
		$fell(reset) |-> busOut.rst [*8])
		else $error("bus reset not asserted at startup");

	reset_frees_a: assert property (@(posedge clock) disable iff (reset)
		foreignReset && !busResetRequest |=> state == ST_FREE && drive == bus_type'(BUS_IDLE)
		##1 !busOut.bsy && !busOut.sel)
		else $error("bus reset did not free the bus");

	inbound_phase_a: assert property (@(posedge clock) disable iff (reset)
		inValid |-> inPhase inside {PHASE_DATA_IN, PHASE_STATUS, PHASE_MSG_IN})
		else $error("inbound byte in an outbound phase");

	attention_pin_a: assert property (@(posedge clock) disable iff (reset)
		attention && !busResetRequest |=> busOut.atn)
		else $error("attention not presented on the bus");

	attention_off_a: assert property (@(posedge clock) disable iff (reset)
		!attention |=> !busOut.atn)
		else $error("attention presented without a pending message");

	target_lines_a: assert property (@(posedge clock) disable iff (reset)
		busOe_n.req && busOe_n.msg && busOe_n.cd && busOe_n.io)
		else $error("host drives a line that only the target may drive");

	select_ok_c: cover property (@(posedge clock) disable iff (reset)
		state == ST_SEL_WAIT ##1 state == ST_INFO);
	inbound_c: cover property (@(posedge clock) disable iff (reset) inValid);
	outbound_c: cover property (@(posedge clock) disable iff (reset) outReady ##[1:20] busOut.ack);
	select_fail_c: cover property (@(posedge clock) disable iff (reset) selectFailed);
	arb_win_c: cover property (@(posedge clock) disable iff (reset) $rose(drive.sel));

endmodule // scsi_bus_initiator

// ### test/scsi_target_model.sv
// behavioural target peripheral that answers the bus initiator
module scsi_target_model
	import scsi_initiator_pkg::*;
(
	input  wire logic    clock,
	input  wire bus_type busIn,
	output bus_type      tgt
);
	timeunit 1ns;
	timeprecision 1ps;

	// extra cycles before each answer, so both prompt and slow targets are seen
	int lat = 0;

	// released lines float to the negated level of the terminators
	initial tgt = bus_type'(18'h00000);

	// ============================================================
	// selection
	task automatic await_select(input logic [2:0] id, output logic [8:0] seen, output logic ok);
		ok = 1'b0;
		seen = 9'h000;
		for (int i = 0; i < 2000 && !ok; i++) begin
			@(posedge clock);
			if (busIn.sel === 1'b1 && busIn.bsy === 1'b0 && busIn.data[id] === 1'b1) begin
				ok = 1'b1;
				seen = {busIn.data, busIn.parity};
			end
		end
		repeat (lat + 1) @(posedge clock);
		tgt.bsy <= 1'b1;
		for (int i = 0; i < 200 && busIn.sel !== 1'b0; i++)
			@(posedge clock);
	endtask

	// ============================================================
	// one byte handshake in the given phase {msg, cd, io}
	task automatic xfer(input logic [2:0] ph, input logic [7:0] b, output logic [8:0] got, output logic ok);
		ok = 1'b0;
		repeat (lat + 1) @(posedge clock);
		{tgt.msg, tgt.cd, tgt.io} <= ph;
		tgt.data <= ph[0] ? b : 8'h00;
		tgt.parity <= ph[0] ? ~^b : 1'h0;
		@(posedge clock);
		tgt.req <= 1'h1;
		for (int i = 0; i < 200 && !ok; i++) begin
			@(posedge clock);
			ok = (busIn.ack === 1'b1);
		end
		got = {busIn.data, busIn.parity};
		tgt.req <= 1'h0;
		tgt.data <= 8'h00;
		tgt.parity <= 1'h0;
		for (int i = 0; i < 200 && busIn.ack !== 1'b0; i++)
			@(posedge clock);
		ok = ok && (busIn.ack === 1'b0);
	endtask

	// ============================================================
	// end of transaction: everything released, bus goes free
	task automatic release_bus();
		repeat (lat + 1) @(posedge clock);
		tgt <= bus_type'(18'h00000);
	endtask

endmodule // scsi_target_model

// ### test/tb.sv
// self-checking bench: initiator against a behavioural target
module tb
	import scsi_initiator_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clock = 1'b0;
	logic        reset = 1'b1;
	logic        startRequest = 1'b0;
	logic [2:0]  targetId = 3'h0;
	logic        attentionRequest = 1'b0;
	logic        busResetRequest = 1'b0;
	logic [7:0]  outByte = 8'h00;
	logic        outValid = 1'b0;
	logic        outLast = 1'b0;
	logic        outReady, inValid, busy, done, selectFailed, sawFail, ok;
	logic [7:0]  inByte;
	phase_type   inPhase, busPhase;
	bus_type     busOut, busOe_n, tgt, busIn;
	logic [10:0] inQ[$], expQ[$];
	int          failures = 0;
	int          checkCount = 0;

	always #4 clock = ~clock;

	// wire levels: host lines where enabled, ored with the target
	assign busIn = bus_type'((busOut & ~busOe_n) | tgt);

	scsi_bus_initiator #(.SELECT_TIMEOUT_CYCLES(200)) DUT (.clock(clock), .reset(reset),
		.startRequest(startRequest), .targetId(targetId), .attentionRequest(attentionRequest),
		.busResetRequest(busResetRequest), .outByte(outByte), .outValid(outValid), .outLast(outLast),
		.outReady(outReady), .inByte(inByte), .inValid(inValid), .inPhase(inPhase), .busPhase(busPhase),
		.busy(busy), .done(done), .selectFailed(selectFailed), .busIn(busIn), .busOut(busOut),
		.busOe_n(busOe_n));

	scsi_target_model model (.clock(clock), .busIn(busIn), .tgt(tgt));

	always @(negedge clock)
		if (inValid === 1'b1)
			inQ.push_back({inPhase, inByte});

	// ============================================================
	// expectations and checking
	function automatic logic oddp(input logic [7:0] b);
		return ~^b;
	endfunction

	function automatic logic [8:0] selExp(input logic [2:0] id);
		logic [7:0] d;
		d = 8'h80 | (8'h01 << id);
		return {d, oddp(d)};
	endfunction

	task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
		checkCount++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d failures %0d", checkCount, failures);
		if (failures == 0 && checkCount > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic await(input string what, input bit forDone, input int limit);
		int i;
		for (i = 0; i < limit; i++) begin
			@(negedge clock);
			if (forDone ? (done === 1'b1) : (busy === 1'b0))
				break;
		end
		sawFail = selectFailed;
		if (i == limit) begin
			check(what, 12'h001, 12'h000);
			end_of_test();
		end
	endtask

	task automatic feed(input logic [7:0] b, input logic last);
		int i;
		@(negedge clock);
		outByte = b;
		outLast = last;
		outValid = 1'b1;
		for (i = 0; i < 2000 && outReady !== 1'b1; i++)
			@(negedge clock);
		outValid = 1'b0;
		outLast = 1'b0;
		check("byte taken", 12'h001, outReady);
	endtask

	// ============================================================
	// one full transaction
	task automatic transact(input logic [2:0] id, input logic atn);
		logic [7:0] cmd[6];
		logic [8:0] got;
		logic [7:0] b;
		logic [2:0] ph;
		logic [7:0] dout;
		foreach (cmd[i]) cmd[i] = 8'($urandom);
		dout = 8'($urandom);
		model.lat = $urandom % 8;
		expQ.delete();
		inQ.delete();
		fork
			begin
				@(negedge clock);
				startRequest = 1'b1;
				targetId = id;
				@(negedge clock);
				startRequest = 1'b0;
				attentionRequest = atn;
				@(negedge clock);
				attentionRequest = 1'b0;
				foreach (cmd[i]) feed(cmd[i], 1'b0);
				if (atn) feed(8'h06, 1'b1);
				feed(dout, 1'b0);
			end
			begin
				model.await_select(id, got, ok);
				check("selection", {3'h0, selExp(id)}, {3'h0, got});
				foreach (cmd[i]) begin
					model.xfer(3'h2, 8'h00, got, ok);
					check("command byte", {3'h1, cmd[i], oddp(cmd[i])}, {2'h0, ok, got});
				end
				check("command phase", 12'h002, {9'h000, busPhase});
				if (atn) begin
					check("attention", 12'h001, busIn.atn);
					model.xfer(3'h6, 8'h00, got, ok);
					check("message out", {3'h1, 8'h06, oddp(8'h06)}, {2'h0, ok, got});
				end
				model.xfer(3'h0, 8'h00, got, ok);
				check("data out", {3'h1, dout, oddp(dout)}, {2'h0, ok, got});
				check("data out phase", 12'h000, {9'h000, busPhase});
				for (int k = 0; k < 5; k++) begin
					ph = (k < 2) ? 3'h1 : ((k == 2) ? 3'h3 : 3'h7);
					b = 8'($urandom);
					expQ.push_back({ph, b});
					model.xfer(ph, b, got, ok);
					check("inbound handshake", 12'h001, ok);
				end
				check("attention cleared", 12'h000, busIn.atn);
				check("message in phase", 12'h007, {9'h000, busPhase});
				model.release_bus();
			end
		join
		await("transaction end", 1'b1, 400);
		check("end without fail", 12'h000, sawFail);
		check("inbound count", 12'(expQ.size()), 12'(inQ.size()));
		foreach (expQ[i]) check("inbound byte", {1'h0, expQ[i]}, {1'h0, (i < inQ.size()) ? inQ[i] : 11'h7FF});
	endtask

	// ============================================================
	// main sequence
	initial begin
		void'($urandom(94781));
		repeat (3) @(posedge clock);
		@(negedge clock);
		reset = 1'b0;
		@(negedge clock);
		check("startup reset", 12'h006, {9'h000, busy, busOut.rst, busOe_n.rst});
		await("reset hold", 1'b0, 4000);
		@(negedge clock);
		check("reset released", 12'h000, busIn.rst);
		transact(3'h0, 1'h1);
		transact(3'h6, 1'h0);
		for (int n = 0; n < 3; n++) transact(3'($urandom % 7), 1'(n));
		@(negedge clock);
		startRequest = 1'b1;
		targetId = 3'h5;
		@(negedge clock);
		startRequest = 1'b0;
		await("select timeout", 1'b1, 2000);
		check("select failed", 12'h001, sawFail);
		busResetRequest = 1'b1;
		@(negedge clock);
		busResetRequest = 1'b0;
		@(negedge clock);
		check("bus reset request", 12'h006, {9'h000, busy, busOut.rst, busOe_n.rst});
		await("bus reset hold", 1'b0, 4000);
		transact(3'h2, 1'h1);
		end_of_test();
	end

endmodule // tb
